// file: hdl/mhf_pkg.sv
// Constants, state codes and carrier types for the multicast hash filter.
// Assumes a single 50 MHz clock domain shared by all users of the package.
package mhf_pkg;

  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [7:0] MHF_CTRL_OFS   = 8'h00;
  localparam logic [7:0] MHF_BASE_OFS   = 8'h04;
  localparam logic [7:0] MHF_START_OFS  = 8'h08;
  localparam logic [7:0] MHF_CFG_OFS    = 8'h0c;
  localparam logic [7:0] MHF_STAT_OFS   = 8'h10;
  localparam logic [7:0] MHF_HASHL_OFS  = 8'h14;
  localparam logic [7:0] MHF_HASHH_OFS  = 8'h18;

  localparam int MHF_CTRL_START_BIT   = 0;
  localparam int MHF_CTRL_RESUME_BIT  = 1;
  localparam int MHF_CTRL_SWRST_BIT   = 2;
  localparam int MHF_CFG_CNA_EN_BIT   = 0;
  localparam int MHF_CFG_MC_ALL_BIT   = 3;
  localparam int MHF_CFG_MULTI_IA_BIT = 6;

  // ****************************************
  // Command block layout
  // ****************************************
  localparam logic [31:0] MHF_CB_CMD_OFS  = 32'h0000_0000;
  localparam logic [31:0] MHF_CB_LINK_OFS = 32'h0000_0004;
  localparam logic [31:0] MHF_CB_CNT_OFS  = 32'h0000_0008;
  localparam logic [31:0] MHF_CB_LIST_OFS = 32'h0000_000c;
  localparam logic [31:0] MHF_WORD_STEP   = 32'h0000_0004;
  // Bit positions within the upper half (command word bits 31:16)
  localparam int          MHF_EOL_BIT     = 15;
  localparam int          MHF_SUSP_BIT    = 14;
  localparam int          MHF_INTR_BIT    = 13;
  localparam logic [2:0]  MHF_CMD_MCAST   = 3'h3;
  localparam int          MHF_CNT_W       = 14;
  localparam int          MHF_GROUP_LAST  = 5;

  // ****************************************
  // Hashing
  // ****************************************
  localparam logic [31:0] MHF_CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] MHF_CRC_POLY = 32'hedb8_8320;

  typedef enum logic [2:0] {
    MHF_S_IDLE = 3'b000,
    MHF_S_SUSP = 3'b001,
    MHF_S_CMD  = 3'b010,
    MHF_S_LINK = 3'b011,
    MHF_S_CNT  = 3'b100,
    MHF_S_LIST = 3'b101,
    MHF_S_BYTE = 3'b110,
    MHF_S_STAT = 3'b111
  } mhf_cu_state_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mhf_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic [47:0] da;
  } mhf_rx_chk_t;

  typedef struct packed {
    logic        done;
    logic        idle;
    logic        not_active;
  } mhf_events_t;

endpackage

// file: hdl/mhf_filter.sv
// Multicast-setup execution for the command unit plus the receive hash filter.
// Assumes a host memory port with a one-cycle ack and an APB master for registers.
//
// How it works
// - Command code 011 in bits 18:16 selects the multicast setup sequence.
// - End-of-list block: unit goes idle and always signals unit idle.
// - Suspend flag: unit suspends; not-active event only when configured.
// - Interrupt-after flag gives a command-done event; otherwise none.
// - Host clears completion flag; device writes it to one when done.
// - Success flag set on clean run; clear with completion means error.
// - Next block address is unit base plus the block's link value.
// - Fourteen-bit count used as multiple of six, rounded down.
// - Zero count leaves the hash table cleared.
// - Group and station entries hash identically into one table.
// - Start, save count, run list transfer, wait for hashing, complete.
// - List bytes travel from memory into the hashing machine.
// - A 64-bit hash table is consulted for received destinations.
// - Clear table, CRC each six bytes, set bit at CRC bits 7:2.
// - An incomplete trailing group leaves the table unchanged.
// - Hashing machine tells the command unit when the update finished.
// - Group destination with a set hashed bit is accepted.
// - Software reset forces the whole hash table to zero.
// - Station hashing bit extends the table to individual destinations.
// - Accept-all bit accepts every group destination.
`timescale 1ns/1ps
`default_nettype none

module mhf_filter
  import mhf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output mhf_mem_req_t      mem_o,
  input  wire logic [31:0]  mem_rdata,
  input  wire logic         mem_ack,
  input  wire mhf_rx_chk_t  rx_i,
  output logic              rx_done,
  output logic              rx_accept,
  output mhf_events_t       events_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mhf_cu_state_t          cu;
    mhf_mem_req_t           mem;
    logic [31:0]            base;
    logic [31:0]            start;
    logic [31:0]            cur;
    logic [31:0]            link;
    logic [15:0]            cmdw;
    logic                   ok;
    logic [MHF_CNT_W-1:0]   left;
    logic [31:0]            word;
    logic [1:0]             bidx;
    logic [2:0]             gidx;
    logic [47:0]            grp;
    logic [63:0]            hash;
    logic                   cfg_cna;
    logic                   cfg_all;
    logic                   cfg_mia;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    mhf_events_t            ev;
    logic                   rx_done;
    logic                   rx_acc;
  } mhf_state_t;

  localparam mhf_state_t MHF_RESET_ST = '0;

  mhf_state_t st_reg;
  mhf_state_t st_next;

  // Ethernet CRC, LSB first, no final inversion; index from bits 7:2
  function automatic logic [5:0] mhf_hash_idx(input logic [47:0] d);
    logic [31:0] c;
    c = MHF_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ MHF_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c[7:2];
  endfunction

  function automatic mhf_mem_req_t mhf_read(input logic [31:0] a);
    mhf_mem_req_t r;
    r.req   = 1'b1;
    r.we    = 1'b0;
    r.addr  = a;
    r.wdata = '0;
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0]  byte_v;
    logic [47:0] grp_v;
    logic [5:0]  idx_v;
    logic        grp_bit;
    logic        hit;
    logic        apb_wr;
    byte_v  = '0;
    grp_v   = '0;
    idx_v   = '0;
    grp_bit = 1'b0;
    hit     = 1'b0;
    apb_wr  = 1'b0;
    st_next = st_reg;
    st_next.ev = '0;

    unique case (st_reg.cu)
      MHF_S_IDLE, MHF_S_SUSP: begin
      end
      MHF_S_CMD: begin
        if (mem_ack) begin
          st_next.cmdw = mem_rdata[31:16];
          st_next.ok   = (mem_rdata[18:16] == MHF_CMD_MCAST);
          st_next.mem  = mhf_read(st_reg.base + st_reg.cur + MHF_CB_LINK_OFS);
          st_next.cu   = MHF_S_LINK;
        end
      end
      MHF_S_LINK: begin
        if (mem_ack) begin
          st_next.link = mem_rdata;
          if (st_reg.ok) begin
            st_next.mem = mhf_read(st_reg.base + st_reg.cur + MHF_CB_CNT_OFS);
            st_next.cu  = MHF_S_CNT;
          end else begin
            // Unknown action: complete with error, table untouched
            st_next.mem = '{req: 1'b1, we: 1'b1, addr: st_reg.base + st_reg.cur,
                            wdata: {st_reg.cmdw, 16'h8000}};
            st_next.cu  = MHF_S_STAT;
          end
        end
      end
      MHF_S_CNT: begin
        if (mem_ack) begin
          st_next.left = mem_rdata[MHF_CNT_W-1:0];
          st_next.hash = '0;
          st_next.gidx = '0;
          if (mem_rdata[MHF_CNT_W-1:0] == '0) begin
            st_next.mem = '{req: 1'b1, we: 1'b1, addr: st_reg.base + st_reg.cur,
                            wdata: {st_reg.cmdw, 16'ha000}};
            st_next.cu  = MHF_S_STAT;
          end else begin
            st_next.mem = mhf_read(st_reg.base + st_reg.cur + MHF_CB_LIST_OFS);
            st_next.cu  = MHF_S_LIST;
          end
        end
      end
      MHF_S_LIST: begin
        if (mem_ack) begin
          st_next.word    = mem_rdata;
          st_next.bidx    = '0;
          st_next.mem.req = 1'b0;
          st_next.cu      = MHF_S_BYTE;
        end
      end
      MHF_S_BYTE: begin
        // One list byte per cycle into the six-byte group
        byte_v = st_reg.word[8*st_reg.bidx +: 8];
        grp_v  = st_reg.grp;
        grp_v[8*st_reg.gidx +: 8] = byte_v;
        st_next.grp  = grp_v;
        st_next.left = st_reg.left - 1'b1;
        if (st_reg.gidx == 3'(MHF_GROUP_LAST)) begin
          st_next.hash[mhf_hash_idx(grp_v)] = 1'b1;
          st_next.gidx = '0;
        end else begin
          st_next.gidx = st_reg.gidx + 1'b1;
        end
        if (st_reg.left == MHF_CNT_W'(1)) begin
          // Partial group is simply dropped: count rounds down to sixes
          st_next.mem = '{req: 1'b1, we: 1'b1, addr: st_reg.base + st_reg.cur,
                          wdata: {st_reg.cmdw, 16'ha000}};
          st_next.cu  = MHF_S_STAT;
        end else if (st_reg.bidx == 2'h3) begin
          st_next.mem = mhf_read(st_reg.mem.addr + MHF_WORD_STEP);
          st_next.cu  = MHF_S_LIST;
        end else begin
          st_next.bidx = st_reg.bidx + 1'b1;
        end
      end
      MHF_S_STAT: begin
        if (mem_ack) begin
          st_next.mem         = '0;
          st_next.ev.done     = st_reg.cmdw[MHF_INTR_BIT];
          st_next.cur         = st_reg.link;
          if (st_reg.cmdw[MHF_EOL_BIT]) begin
            st_next.cu      = MHF_S_IDLE;
            st_next.ev.idle = 1'b1;
          end else if (st_reg.cmdw[MHF_SUSP_BIT]) begin
            st_next.cu            = MHF_S_SUSP;
            st_next.ev.not_active = st_reg.cfg_cna;
          end else begin
            st_next.mem = mhf_read(st_reg.base + st_reg.link);
            st_next.cu  = MHF_S_CMD;
          end
        end
      end
    endcase

    // Receive check against the table
    st_next.rx_done = rx_i.valid;
    if (rx_i.valid) begin
      grp_bit = rx_i.da[0];
      hit     = st_reg.hash[mhf_hash_idx(rx_i.da)];
      st_next.rx_acc = grp_bit ? (st_reg.cfg_all | hit)
                               : (st_reg.cfg_mia & hit);
    end

    // ****************************************
    // APB slave: zero wait states, answer in the first access cycle
    // ****************************************
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    if (psel && !penable && !st_reg.pready) begin
      st_next.pready = 1'b1;
      unique case (paddr)
        MHF_CTRL_OFS:  st_next.prdata = '0;
        MHF_BASE_OFS:  st_next.prdata = st_reg.base;
        MHF_START_OFS: st_next.prdata = st_reg.start;
        MHF_CFG_OFS:   st_next.prdata = {25'h0, st_reg.cfg_mia, 2'h0, st_reg.cfg_all, 2'h0, st_reg.cfg_cna};
        MHF_STAT_OFS:  st_next.prdata = {29'h0, st_reg.cu};
        MHF_HASHL_OFS: st_next.prdata = st_reg.hash[31:0];
        MHF_HASHH_OFS: st_next.prdata = st_reg.hash[63:32];
        default: begin
          st_next.prdata  = '0;
          st_next.pslverr = 1'b1;
        end
      endcase
    end

    apb_wr = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
    if (apb_wr) begin
      unique case (paddr)
        MHF_BASE_OFS:  st_next.base  = pwdata;
        MHF_START_OFS: st_next.start = pwdata;
        MHF_CFG_OFS: begin
          st_next.cfg_cna = pwdata[MHF_CFG_CNA_EN_BIT];
          st_next.cfg_all = pwdata[MHF_CFG_MC_ALL_BIT];
          st_next.cfg_mia = pwdata[MHF_CFG_MULTI_IA_BIT];
        end
        MHF_CTRL_OFS: begin
          if (pwdata[MHF_CTRL_START_BIT] && st_reg.cu == MHF_S_IDLE) begin
            st_next.cur = st_reg.start;
            st_next.mem = mhf_read(st_reg.base + st_reg.start);
            st_next.cu  = MHF_S_CMD;
          end
          if (pwdata[MHF_CTRL_RESUME_BIT] && st_reg.cu == MHF_S_SUSP) begin
            st_next.mem = mhf_read(st_reg.base + st_reg.cur);
            st_next.cu  = MHF_S_CMD;
          end
          if (pwdata[MHF_CTRL_SWRST_BIT]) begin
            // Keeps the APB answer in flight; everything else restarts
            st_next        = MHF_RESET_ST;
            st_next.hash   = '0;
            st_next.prdata = st_reg.prdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= MHF_RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign mem_o     = st_reg.mem;
  assign rx_done   = st_reg.rx_done;
  assign rx_accept = st_reg.rx_acc;
  assign events_o  = st_reg.ev;

endmodule

`default_nettype wire

// file: tb/mhf_filter_assertions.sv
// Checker for the multicast hash filter memory port, events and receive answer.
// Assumes one clock domain; bound onto every mhf_filter instance.
`timescale 1ns/1ps
`default_nettype none
module mhf_filter_assertions
  import mhf_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_n,
  input wire mhf_mem_req_t mem_o,
  input wire logic         mem_ack,
  input wire mhf_rx_chk_t  rx_i,
  input wire logic         rx_done,
  input wire mhf_events_t  events_o
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ********************
  // Status write, events
  // ********************
  sequence s_stat_ack;
    mem_ack && mem_o.req && mem_o.we;
  endsequence
  property p_done; s_stat_ack |=> events_o.done == $past(mem_o.wdata[29]); endproperty
  a_done: assert property (p_done) else $error("done event mismatch");
  property p_idle; s_stat_ack |=> events_o.idle == $past(mem_o.wdata[31]); endproperty
  a_idle: assert property (p_idle) else $error("idle event mismatch");
  property p_susp; s_stat_ack ##0 !mem_o.wdata[31] && !mem_o.wdata[30] |=> !events_o.not_active; endproperty
  a_susp: assert property (p_susp) else $error("not-active event without suspend");
  // Not-active only ever follows the status write of a suspending block
  property p_cna; events_o.not_active |-> $past(mem_ack && mem_o.req && mem_o.we && mem_o.wdata[30] && !mem_o.wdata[31]);
  endproperty
  a_cna: assert property (p_cna) else $error("not-active event without suspend block");
  property p_ev_src; events_o != '0 |-> $past(mem_ack && mem_o.we); endproperty
  a_ev_src: assert property (p_ev_src) else $error("event before completion");
  property p_stat_fmt; mem_o.req && mem_o.we |-> mem_o.wdata[15:14] == 2'h2 && mem_o.wdata[12:0] == 13'h0; endproperty
  a_stat_fmt: assert property (p_stat_fmt) else $error("status word malformed");
  property p_ok_code; mem_o.req && mem_o.we |-> mem_o.wdata[13] == (mem_o.wdata[18:16] == MHF_CMD_MCAST); endproperty
  a_ok_code: assert property (p_ok_code) else $error("success flag wrong for code");
  // Soft reset may abandon a request, so only its hold is checked
  property p_req_hold; mem_o.req && !mem_ack |=> !mem_o.req || $stable(mem_o); endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request changed");
  // ********************
  // Receive check
  // ********************
  property p_rx_ans; rx_i.valid |=> rx_done; endproperty
  a_rx_ans: assert property (p_rx_ans) else $error("no receive answer");
  property p_rx_src; rx_done |-> $past(rx_i.valid); endproperty
  a_rx_src: assert property (p_rx_src) else $error("spurious receive answer");
endmodule
bind mhf_filter mhf_filter_assertions mhf_filter_assertions_i (.clk, .rst_n, .mem_o, .mem_ack, .rx_i, .rx_done,
  .events_o);
`default_nettype wire

// file: tb/mhf_host_mem.sv
// Host memory holding command blocks; acks each request lat+1 cycles after it is raised.
// Assumes requests are held until acked; the bench fills ram directly.
`timescale 1ns/1ps
`default_nettype none
module mhf_host_mem
  import mhf_pkg::*;
(
  input  wire logic         clk,
  input  wire mhf_mem_req_t mem_o,
  input  wire logic [1:0]   lat,
  output logic [31:0]       mem_rdata,
  output logic              mem_ack
);
  logic [31:0] ram [256];
  logic [31:0] last = 32'h0;
  logic [1:0]  wait_cnt = 2'h0;
  logic        ack_q = 1'h0;
  // Plain always: the bench also loads ram directly
  always @(posedge clk) begin
    ack_q <= 1'h0;
    if (ack_q && mem_o.we) begin
      ram[mem_o.addr[9:2]] <= mem_o.wdata;
    end
    if (!mem_o.req || ack_q) begin
      wait_cnt <= 2'h0;
    end else if (wait_cnt == lat) begin
      ack_q <= 1'h1;
      last <= ram[mem_o.addr[9:2]];
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  // Released bus shows inverted data, never a stale copy
  assign mem_rdata = ack_q ? last : ~last;
  assign mem_ack = ack_q;
endmodule
`default_nettype wire

// file: tb/tb_mhf_filter.sv
// Bench for the multicast hash filter: APB master, host memory, receive checks.
// Assumes mhf_host_mem as memory side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_mhf_filter
  import mhf_pkg::*;
;
  logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_ack, rx_done, rx_accept;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, mem_rdata;
  logic [1:0]   lat;
  logic [63:0]  hash_exp;
  mhf_mem_req_t mem_o;
  mhf_rx_chk_t  rx_i;
  mhf_events_t  events_o;
  int           fail_count, comparisons, cycles;
  localparam logic [47:0] E0 = 48'h6655_4433_2201, E1 = 48'h1a2b_3c4d_5e02, E2 = 48'h0e0d_0c0b_0a03;
  mhf_filter mhf_filter_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_o, .mem_rdata, .mem_ack, .rx_i, .rx_done, .rx_accept, .events_o);
  mhf_host_mem mhf_host_mem_i (.clk, .mem_o, .lat, .mem_rdata, .mem_ack);
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Ends on pready; if pready never comes, only the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q; logic e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q; logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(64'(q), 64'(x));
  endtask
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = MHF_CRC_INIT;
    for (int i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ da[i]) ? MHF_CRC_POLY : 32'h0);
    return c[7:2];
  endfunction
  function automatic logic acc(input logic [47:0] da, input logic [7:0] cfg);
    return da[0] ? (cfg[MHF_CFG_MC_ALL_BIT] | hash_exp[hidx(da)]) : (cfg[MHF_CFG_MULTI_IA_BIT] & hash_exp[hidx(da)]);
  endfunction
  task automatic put_blk(input logic [7:0] i, input logic [31:0] cmd, lnk, cnt, input logic [95:0] l,
                         input logic [31:0] t);
    mhf_host_mem_i.ram[i] = cmd;
    mhf_host_mem_i.ram[i+1] = lnk;
    mhf_host_mem_i.ram[i+2] = cnt;
    for (int k = 0; k < 3; k++) mhf_host_mem_i.ram[i+3+k] = l[32*k +: 32];
    mhf_host_mem_i.ram[i+6] = t;
  endtask
  task automatic wait_ev(output logic [2:0] s);
    s = 3'h0;
    for (int n = 0; n < 500 && !(s[1] | s[0]); n++) begin
      @(negedge clk);
      s = s | 3'(events_o);
    end
  endtask
  task automatic rx_chk(input logic [47:0] da, input logic x);
    @(posedge clk);
    rx_i <= '{1'h1, da};
    @(posedge clk);
    rx_i.valid <= 1'h0;
    @(negedge clk);
    chk(64'(rx_done), 64'h1);
    chk(64'(rx_accept), 64'(x));
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_regs();
    logic [31:0] q; logic e;
    rdc(MHF_STAT_OFS, 32'h0);
    rdc(MHF_HASHH_OFS, 32'h0);
    wr(MHF_CFG_OFS, 32'h49);
    rdc(MHF_CFG_OFS, 32'h49);
    apb(1'h0, 8'h1c, 32'h0, q, e);
    chk({31'h0, e, q}, 64'h1_0000_0000);
  endtask
  task automatic t_setup();
    logic [2:0] s;
    logic [47:0] das [5] = '{E0, E1, E2, 48'h11, 48'h10};
    logic [7:0] cfgs [3] = '{8'h00, 8'h08, 8'h40};
    put_blk(8'h40, 32'ha003_0000, 32'h0, 32'hd, {E1, E0}, 32'ha5a5_a5ff);
    hash_exp = (64'h1 << hidx(E0)) | (64'h1 << hidx(E1));
    lat = 2'h2;
    wr(MHF_BASE_OFS, 32'h100);
    wr(MHF_START_OFS, 32'h0);
    wr(MHF_CTRL_OFS, 32'h1);
    wait_ev(s);
    chk(64'(s), 64'h6);
    chk(64'(mhf_host_mem_i.ram[8'h40]), 64'ha003_a000);
    rdc(MHF_HASHL_OFS, hash_exp[31:0]);
    rdc(MHF_HASHH_OFS, hash_exp[63:32]);
    foreach (cfgs[c]) begin
      wr(MHF_CFG_OFS, 32'(cfgs[c]));
      foreach (das[k]) rx_chk(das[k], acc(das[k], cfgs[c]));
    end
  endtask
  task automatic t_swrst();
    wr(MHF_CTRL_OFS, 32'h4);
    rdc(MHF_HASHL_OFS, 32'h0);
    rdc(MHF_HASHH_OFS, 32'h0);
  endtask
  task automatic t_chain();
    logic [2:0] s;
    put_blk(8'h40, 32'h4003_0000, 32'h40, 32'h6, 96'(E2), 32'h0);
    put_blk(8'h50, 32'h0001_0000, 32'h80, 32'h0, 96'h0, 32'h0);
    put_blk(8'h60, 32'h8003_0000, 32'h0, 32'h0, 96'h0, 32'h0);
    hash_exp = 64'h1 << hidx(E2);
    lat = 2'h0;
    wr(MHF_BASE_OFS, 32'h100);
    wr(MHF_CFG_OFS, 32'h1);
    wr(MHF_CTRL_OFS, 32'h1);
    wait_ev(s);
    chk(64'(s), 64'h1);
    rdc(MHF_STAT_OFS, 32'h1);
    rdc(MHF_HASHL_OFS, hash_exp[31:0]);
    rdc(MHF_HASHH_OFS, hash_exp[63:32]);
    wr(MHF_CTRL_OFS, 32'h2);
    wait_ev(s);
    chk(64'(s), 64'h2);
    chk(64'(mhf_host_mem_i.ram[8'h50]), 64'h0001_8000);
    chk(64'(mhf_host_mem_i.ram[8'h60]), 64'h8003_a000);
    rdc(MHF_HASHL_OFS, 32'h0);
    rdc(MHF_HASHH_OFS, 32'h0);
  endtask
  initial begin
    rst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0; pwdata = 32'h0;
    rx_i = '0; lat = 2'h0; fail_count = 0; comparisons = 0; cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_setup();
    t_swrst();
    t_chain();
    end_sim();
  end
endmodule
`default_nettype wire
